// File: flash_seq_consts.svh
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

`define ADDR_W 16
`define DATA_W 8
`define ARR_IDX_W 14
`define ARR_BYTES 12336

`define CTRL_OFFSET 16'hFE08
`define BOUNDARY_OFFSET 16'hFE09
`define MAIN_LO 16'hC000
`define MAIN_HI 16'hEFFF
`define VEC_LO 16'hFFD0
`define VEC_BASE_IDX 14'h3000
`define PROT_TOP 16'hFFFF

`define CTRL_HV_BIT 3
`define CTRL_WHOLE_BIT 2
`define CTRL_WIPE_BIT 1
`define CTRL_PROG_BIT 0

`define CTRL_RESET 4'h0
`define BOUNDARY_RESET 8'h00
`define BOUNDARY_OPEN 8'hFF
`define ERASED_BYTE 8'hFF
`define ZERO_BYTE 8'h00
`define PAGE_BYTES 128
`define PAGE_LSB 7
`define ROW_LSB 6

`define CLK_PERIOD_NS 100
`define T_NVS_NS 10000
`define PROG_SETUP_DELAY_NS 5000
`define T_ERASE_NS 1000000
`define T_MERASE_NS 4000000
`define NVS_CYC ((`T_NVS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PGS_CYC ((`PROG_SETUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16
`define CNT_MAX 16'hFFFF

`endif

// File: flash_seq_pkg.sv
package flash_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LATCHED = 2'b01,
    ST_HV = 2'b11
  } seq_state_t;
  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
endpackage : flash_seq_pkg

// File: flash_program_erase_protect.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "flash_seq_consts.svh"

module flash_program_erase_protect #(
  parameter int unsigned ERASE_CYC = `T_ERASE_NS / `CLK_PERIOD_NS,
  parameter int unsigned MERASE_CYC = `T_MERASE_NS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire flash_seq_pkg::addr_t address,
  input wire logic read,
  input wire logic write,
  input wire flash_seq_pkg::byte_t writedata,
  output flash_seq_pkg::byte_t readdata,
  output logic waitrequest,
  output logic high_voltage_on
);
  import flash_seq_pkg::*;

  localparam logic [`CNT_W-1:0] NVS_CNT = `CNT_W'(`NVS_CYC);
  localparam logic [`CNT_W-1:0] PGS_CNT = `CNT_W'(`PGS_CYC);
  localparam logic [`CNT_W-1:0] ERASE_CNT = `CNT_W'(ERASE_CYC);
  localparam logic [`CNT_W-1:0] MERASE_CNT = `CNT_W'(MERASE_CYC);

  // nonvolatile: no reset, contents survive rst_n
  byte_t mem [`ARR_BYTES];

  logic whole_r;
  logic wipe_r;
  logic prog_r;
  byte_t boundary_bits_r;
  addr_t lat_addr_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [`CNT_W-1:0] elapsed_r;
  logic [`CNT_W-1:0] elapsed_nxt;

  function automatic logic in_main(input addr_t a);
    in_main = (a >= `MAIN_LO) && (a <= `MAIN_HI);
  endfunction : in_main

  function automatic logic in_vec(input addr_t a);
    in_vec = (a >= `VEC_LO);
  endfunction : in_vec

  function automatic logic [`ARR_IDX_W-1:0] arr_index(input addr_t a);
    addr_t off;
    off = in_vec(a) ? (a - `VEC_LO) : (a - `MAIN_LO);
    arr_index = in_vec(a) ? (`VEC_BASE_IDX + off[`ARR_IDX_W-1:0]) : off[`ARR_IDX_W-1:0];
  endfunction : arr_index

  // protection start and hit test
  function automatic addr_t prot_start(input byte_t b);
    prot_start = {2'b11, b[7:1], 7'b000_0000};
  endfunction : prot_start

  function automatic logic prot_hit(input byte_t b, input addr_t a);
    prot_hit = (b != `BOUNDARY_OPEN) && (a >= prot_start(b)) && (a <= `PROT_TOP);
  endfunction : prot_hit

  // bus decode: one wait state, so every access answers on the second edge
  wire req = read || write;
  wire accept = req && !waitrequest;
  wire wr_go = write && accept;
  wire hit_ctrl = (address == `CTRL_OFFSET);
  wire hit_bound = (address == `BOUNDARY_OFFSET);
  wire hit_arr = in_main(address) || in_vec(address);
  wire [`ARR_IDX_W-1:0] rd_idx = arr_index(address);
  wire [3:0] ctrl_view = {high_voltage_on, whole_r, wipe_r, prog_r};
  wire byte_t rd_mux = hit_ctrl ? {4'h0, ctrl_view} :
                       hit_bound ? boundary_bits_r :
                       hit_arr ? mem[rd_idx] : `ZERO_BYTE;

  // control register write decode
  wire ctrl_wr = wr_go && hit_ctrl;
  wire sel_clash = writedata[`CTRL_PROG_BIT] && writedata[`CTRL_WIPE_BIT];
  wire prog_nxt = ctrl_wr ? (sel_clash ? prog_r : writedata[`CTRL_PROG_BIT]) : prog_r;
  wire wipe_nxt = ctrl_wr ? (sel_clash ? wipe_r : writedata[`CTRL_WIPE_BIT]) : wipe_r;
  wire whole_nxt = ctrl_wr ? writedata[`CTRL_WHOLE_BIT] : whole_r;
  wire lat_prot = prot_hit(boundary_bits_r, lat_addr_r);
  wire hv_allow = (prog_nxt || wipe_nxt) && (state_r == ST_LATCHED) &&
                  (elapsed_r >= NVS_CNT) && !lat_prot;
  wire hv_nxt = ctrl_wr ? (writedata[`CTRL_HV_BIT] && (high_voltage_on || hv_allow)) : high_voltage_on;
  wire hv_rise = hv_nxt && !high_voltage_on;

  // array write roles
  wire arr_wr = wr_go && hit_arr;
  wire latch_go = arr_wr && (state_r == ST_IDLE) && (prog_r || wipe_r);
  wire same_row = (address[15:`ROW_LSB] == lat_addr_r[15:`ROW_LSB]);
  wire prog_go = arr_wr && (state_r == ST_HV) && prog_r && high_voltage_on &&
                 same_row && (elapsed_r >= PGS_CNT);
  wire [`ARR_IDX_W-1:0] wr_idx = arr_index(address);

  // erase completes when wipe drops under high voltage after the hold time
  wire [`CNT_W-1:0] erase_need = whole_r ? MERASE_CNT : ERASE_CNT;
  wire erase_go = ctrl_wr && wipe_r && !wipe_nxt && high_voltage_on &&
                  (state_r == ST_HV) && (elapsed_r >= erase_need);
  wire mass_go = erase_go && whole_r;
  wire page_go = erase_go && !whole_r && !in_vec(lat_addr_r);
  wire [`ARR_IDX_W-1:0] page_idx = arr_index({lat_addr_r[15:`PAGE_LSB], 7'b000_0000});

  // sequencer: unrelated accesses never move it, only these events do
  always_comb begin
    state_nxt = state_r;
    elapsed_nxt = (elapsed_r == `CNT_MAX) ? elapsed_r : elapsed_r + 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (latch_go) begin
          state_nxt = ST_LATCHED;
          elapsed_nxt = '0;
        end
      end
      ST_LATCHED: begin
        if (hv_rise) begin
          state_nxt = ST_HV;
          elapsed_nxt = '0;
        end else if (!prog_nxt && !wipe_nxt) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HV: begin
        if (!hv_nxt) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= `ZERO_BYTE;
    end else begin
      waitrequest <= !(req && waitrequest);
      readdata <= (req && waitrequest) ? rd_mux : readdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {high_voltage_on, whole_r, wipe_r, prog_r} <= `CTRL_RESET;
      boundary_bits_r <= `BOUNDARY_RESET;
    end else begin
      {high_voltage_on, whole_r, wipe_r, prog_r} <= {hv_nxt, whole_nxt, wipe_nxt, prog_nxt};
      boundary_bits_r <= (wr_go && hit_bound) ? writedata : boundary_bits_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      elapsed_r <= '0;
      lat_addr_r <= `MAIN_LO;
    end else begin
      state_r <= state_nxt;
      elapsed_r <= elapsed_nxt;
      lat_addr_r <= latch_go ? address : lat_addr_r;
    end
  end

  // array cells: erase sets ones, programming can only clear
  always_ff @(posedge clk) begin
    if (mass_go) begin
      for (int i = 0; i < `ARR_BYTES; i++) begin
        mem[i] <= `ERASED_BYTE;
      end
    end else if (page_go) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        mem[`ARR_IDX_W'(page_idx + i)] <= `ERASED_BYTE;
      end
    end else if (prog_go) begin
      mem[wr_idx] <= mem[wr_idx] & writedata;
    end
  end

  ctrl_upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (read && waitrequest && hit_ctrl) |=> (readdata[7:4] == 4'h0))
    else $error("control register upper nibble not zero");

  sel_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(prog_r && wipe_r))
    else $error("prog and wipe selected together");

  hv_needs_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(high_voltage_on) |-> ($past(state_r) == ST_LATCHED) && (prog_r || wipe_r) &&
      ($past(elapsed_r) >= NVS_CNT))
    else $error("high voltage set without proper sequence");

  hv_protect_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(high_voltage_on) |-> !prot_hit($past(boundary_bits_r), $past(lat_addr_r)))
    else $error("high voltage set on protected address");

  full_protect_a: assert property (@(posedge clk) disable iff (!rst_n)
    (boundary_bits_r[7:1] == 7'h00) |-> lat_prot || (lat_addr_r < `MAIN_LO))
    else $error("zero boundary must protect whole array");

  open_boundary_a: assert property (@(posedge clk) disable iff (!rst_n)
    (boundary_bits_r == `BOUNDARY_OPEN) |-> !lat_prot)
    else $error("boundary FF must disable protection");

  latch_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    latch_go |=> (lat_addr_r == $past(address)) && (state_r == ST_LATCHED) && (elapsed_r == '0))
    else $error("dummy write address not latched");

  bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait state");

  prog_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    prog_go |=> ((mem[$past(wr_idx)] & ~$past(mem[wr_idx])) == `ZERO_BYTE))
    else $error("programming set a bit");

  wait_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  hv_tracks_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    high_voltage_on == (state_r == ST_HV))
    else $error("high voltage out of step with sequencer");

  hv_by_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(high_voltage_on) |-> $past(ctrl_wr))
    else $error("high voltage set without a control write");

  latched_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_LATCHED) |-> (prog_r || wipe_r))
    else $error("latched state without a select bit");

  sel_clash_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_wr && sel_clash) |=> (prog_r == $past(prog_r)) && (wipe_r == $past(wipe_r)))
    else $error("clashing select write changed the selects");

  bound_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && hit_bound) |=> (boundary_bits_r == $past(writedata)))
    else $error("boundary write not taken");

  bound_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (read && waitrequest && hit_bound) |=> (readdata == $past(boundary_bits_r)))
    else $error("boundary read returned wrong value");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (read && waitrequest && !hit_ctrl && !hit_bound && !hit_arr) |=> (readdata == `ZERO_BYTE))
    else $error("unmapped read not zero");

  mass_erased_a: assert property (@(posedge clk) disable iff (!rst_n)
    mass_go |=> (mem[`VEC_BASE_IDX] == `ERASED_BYTE))
    else $error("mass erase left vector page programmed");

  page_erased_a: assert property (@(posedge clk) disable iff (!rst_n)
    page_go |=> (mem[$past(page_idx)] == `ERASED_BYTE))
    else $error("page erase left page base programmed");

  elapsed_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (elapsed_r == `CNT_MAX) |=> ((elapsed_r == `CNT_MAX) || (elapsed_r == '0)))
    else $error("wait counter wrapped");

  page_done_c: cover property (@(posedge clk) disable iff (!rst_n) page_go);
  mass_done_c: cover property (@(posedge clk) disable iff (!rst_n) mass_go);
  prog_byte_c: cover property (@(posedge clk) disable iff (!rst_n) prog_go);
  hv_refused_c: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr && writedata[`CTRL_HV_BIT] && (state_r == ST_LATCHED) && lat_prot);
endmodule : flash_program_erase_protect

// File: flash_program_erase_protect_bench.sv
`timescale 1ns/1ps
`include "flash_seq_consts.svh"

module flash_program_erase_protect_bench;
  import flash_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  addr_t address = 16'h0000;
  logic read = 1'b0;
  logic write = 1'b0;
  byte_t writedata = 8'h00;
  byte_t readdata;
  logic waitrequest;
  logic high_voltage_on;
  int errors = 0;
  int samples_checked = 0;
  byte_t exp_q[$];
  byte_t bound;
  byte_t d1, d2, d3;
  logic [31:0] seed = 32'h0000_5cb3;

  flash_program_erase_protect #(.ERASE_CYC(20), .MERASE_CYC(40)) i_flash_program_erase_protect (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .high_voltage_on(high_voltage_on)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic byte_t rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp_byte(input string name, input byte_t exp, input byte_t got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  // request held until waitrequest is seen low, released only after that edge
  task automatic xfer(input logic is_rd, input addr_t a, input byte_t d);
    int n;
    @(posedge clk);
    address <= a;
    read <= is_rd;
    write <= ~is_rd;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      errors++;
      final_report();
    end
  endtask : xfer

  task automatic wr(input addr_t a, input byte_t d);
    xfer(1'b0, a, d);
  endtask : wr

  task automatic rd(input addr_t a, input byte_t e);
    exp_q.push_back(e);
    xfer(1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // let the registered copy settle before looking
  task automatic hv_check(input logic e);
    @(negedge clk);
    cmp_bit("high_voltage_on", e, high_voltage_on);
  endtask : hv_check

  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
      end else begin
        cmp_byte("readdata", exp_q.pop_front(), readdata);
      end
    end
  end

  // only bus accesses here, as code fetched from RAM would issue
  task automatic erase(input addr_t a, input logic whole);
    wr(`CTRL_OFFSET, {5'b0, whole, 2'b10});
    wr(a, rnd());
    rd(`BOUNDARY_OFFSET, bound);
    idle(105);
    wr(`CTRL_OFFSET, {4'h0, 1'b1, whole, 2'b10});
    hv_check(1'b1);
    idle(whole ? 45 : 25);
    wr(`CTRL_OFFSET, 8'h08);
    idle(whole ? 1000 : 50);
    wr(`CTRL_OFFSET, 8'h00);
    hv_check(1'b0);
    idle(10);
  endtask : erase

  // latch address a, then program d at b; ok says whether high voltage may rise
  task automatic prog(input addr_t a, input addr_t b, input byte_t d, input logic ok);
    wr(`CTRL_OFFSET, 8'h01);
    wr(a, rnd());
    idle(105);
    wr(`CTRL_OFFSET, 8'h09);
    rd(`CTRL_OFFSET, ok ? 8'h09 : 8'h01);
    hv_check(ok);
    idle(55);
    wr(b, d);
    idle(300);
    wr(`CTRL_OFFSET, 8'h08);
    idle(50);
    wr(`CTRL_OFFSET, 8'h00);
    idle(10);
  endtask : prog

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CTRL_OFFSET, 8'h00);
    rd(`BOUNDARY_OFFSET, 8'h00);
    wr(16'h1234, 8'h5A);
    rd(16'h1234, 8'h00);
    bound = rnd();
    wr(`BOUNDARY_OFFSET, bound);
    rd(`BOUNDARY_OFFSET, bound);
    wr(`CTRL_OFFSET, 8'h01);
    wr(`CTRL_OFFSET, 8'h03);
    rd(`CTRL_OFFSET, 8'h01);
    wr(`CTRL_OFFSET, 8'hF4);
    rd(`CTRL_OFFSET, 8'h04);
    wr(`CTRL_OFFSET, 8'h0C);
    rd(`CTRL_OFFSET, 8'h04);
    bound = `BOUNDARY_OPEN;
    wr(`BOUNDARY_OFFSET, bound);
    // array powers up unknown, so everything below starts from a mass erase
    erase(`MAIN_LO, 1'b1);
    rd(`MAIN_LO, `ERASED_BYTE);
    rd(`MAIN_HI, `ERASED_BYTE);
    rd(`VEC_LO, `ERASED_BYTE);
    rd(`PROT_TOP, `ERASED_BYTE);
    rd(16'hF000, 8'h00);
    d1 = rnd() & 8'h7F;
    d2 = rnd() & 8'h7F;
    d3 = rnd() & 8'h7F;
    prog(16'hC040, 16'hC040, d1, 1'b1);
    prog(16'hC0C0, 16'hC0C0, d2, 1'b1);
    prog(`VEC_LO, `VEC_LO, d3, 1'b1);
    prog(16'hC040, 16'hC080, 8'h00, 1'b1);
    prog(16'hC040, 16'hC040, 8'hF0, 1'b1);
    rd(16'hC040, d1 & 8'hF0);
    rd(16'hC0C0, d2);
    rd(`VEC_LO, d3);
    rd(16'hC080, `ERASED_BYTE);
    erase(16'hC07F, 1'b0);
    rd(16'hC040, `ERASED_BYTE);
    rd(16'hC0C0, d2);
    erase(16'hFFE0, 1'b0);
    rd(`VEC_LO, d3);
    bound = 8'h02;
    wr(`BOUNDARY_OFFSET, bound);
    prog(16'hC07F, 16'hC07F, 8'h00, 1'b1);
    prog(16'hC080, 16'hC080, 8'h00, 1'b0);
    rd(16'hC07F, 8'h00);
    rd(16'hC080, `ERASED_BYTE);
    bound = 8'h01;
    wr(`BOUNDARY_OFFSET, bound);
    prog(`MAIN_LO, `MAIN_LO, 8'h00, 1'b0);
    bound = 8'hFE;
    wr(`BOUNDARY_OFFSET, bound);
    prog(16'hFFD1, 16'hFFD1, 8'h00, 1'b0);
    rd(16'hFFD1, `ERASED_BYTE);
    wr(`CTRL_OFFSET, 8'h01);
    wr(16'hC100, 8'h00);
    wr(`CTRL_OFFSET, 8'h09);
    rd(`CTRL_OFFSET, 8'h01);
    wr(`CTRL_OFFSET, 8'h00);
    final_report();
  end
endmodule : flash_program_erase_protect_bench
